//--- inc/cfg_pkg.sv
package cfg_pkg;
    // Configuration mode codes on mode_select_pins
    typedef enum logic [2:0] {
        MODE_MASTER_SERIAL = 3'h0,
        MODE_RESERVED = 3'h1,
        MODE_EXPRESS = 3'h2,
        MODE_PERIPH_SYNC = 3'h3,
        MODE_MASTER_PAR_UP = 3'h4,
        MODE_PERIPH_ASYNC = 3'h5,
        MODE_MASTER_PAR_DOWN = 3'h6,
        MODE_SLAVE_SERIAL = 3'h7
    } cfg_mode_t;

    localparam int unsigned CLK_HZ = 40000000;
    localparam int unsigned ADDR_W = 18;
    localparam int unsigned DATA_W = 8;
    localparam logic [17:0] ADDR_UP_START = 18'h00000;
    localparam logic [17:0] ADDR_DOWN_START = 18'h3FFFF;
    // Extra master wait after init line returns high, microseconds
    localparam int unsigned MASTER_WAIT_MIN_US = 50;
    localparam int unsigned MASTER_WAIT_MAX_US = 250;
    localparam int unsigned MASTER_WAIT_CYC = (MASTER_WAIT_MIN_US * (CLK_HZ / 1000000));
    // Power stabilisation and memory clear time, cycles
    localparam int unsigned CLEAR_CYC = 64;
    // Internal configuration clock half period for master and asynchronous peripheral modes, cycles
    localparam int unsigned CONFIG_CLOCK_HALF_CYC = 20;
    localparam int unsigned FIFO_DEPTH = 8;
endpackage

//--- inc/cfg_stream_if.sv
`timescale 1ns/100ps
// Byte stream between the loader and its buffer
interface cfg_stream_if #(parameter int W = 8) ();
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface

//--- verilog/byte_fifo.sv
`timescale 1ns/100ps
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic i_clk, // System clock
    input wire logic i_rst_n, // Synchronous reset, active low
    input wire logic i_flush, // Drop all contents
    cfg_stream_if.snk wr, // Fill side
    cfg_stream_if.src rd, // Drain side
    output logic o_empty // No word held
);
    localparam int AW = $clog2(DEPTH);

    // Elaboration check: pointer wrap needs a power-of-two depth
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin
        $error("byte_fifo depth must be a power of two");
    end

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW:0] wp_ff;
    logic [AW:0] rp_ff;
    logic [WIDTH-1:0] dout_ff;
    logic dval_ff;
    wire full = (wp_ff[AW] != rp_ff[AW]) && (wp_ff[AW-1:0] == rp_ff[AW-1:0]);
    wire mem_empty = (wp_ff == rp_ff);
    wire push = wr.valid && !full;
    wire load = !mem_empty && (!dval_ff || rd.ready);

    // Handshakes
    assign wr.ready = !full;
    assign rd.valid = dval_ff;
    assign rd.data = dout_ff;
    assign o_empty = mem_empty && !dval_ff;

    // Storage
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_ff[wp_ff[AW-1:0]] <= wr.data;
        end
    end

    // Pointers and registered read data
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || i_flush) begin
            wp_ff <= '0;
            rp_ff <= '0;
            dval_ff <= 1'b0;
            dout_ff <= '0;
        end else begin
            if (push) begin
                wp_ff <= wp_ff + 1'b1;
            end
            if (load) begin
                dout_ff <= mem_ff[rp_ff[AW-1:0]];
                rp_ff <= rp_ff + 1'b1;
                dval_ff <= 1'b1;
            end else if (rd.ready) begin
                dval_ff <= 1'b0;
            end
        end
    end
endmodule

//--- verilog/config_port_pin_logic.sv
`timescale 1ns/100ps
// What this block does
// - High-during-configuration flag stays high until user I/O go active.
// - Low-during-configuration flag stays low until user I/O go active.
// - Init line pulled low during power stabilisation and memory clear.
// - Outside low on init line holds device in wait state.
// - Master modes wait a further 50 to 250 us after init rises.
// - Init line driven low to report a configuration data error.
// - Selected only while select_low_n low and select_high_enable high.
// - In peripheral modes, selected write strobe low loads data bus byte into buffer.
// - In asynchronous peripheral mode, selected read strobe low shows ready on bit 7, others high.
// - Write and read strobes together: write wins, read ignored.
// - Express mode uses select_high_enable as daisy-chain serial enable.
// - Master parallel drives 18-bit PROM address bus stepping through EPROM.
// - Parallel, peripheral and express modes accept eight-bit data bus.
// - Serial modes sample serial input on rising configuration clock edge.
// - Parallel modes use serial input pin as data bit zero.
// - Non-express modes shift data out on falling configuration clock edges.
// - Express mode serial output goes high for one cycle only, when loading completes, then returns low.
// - Without scan macro, scan functions disabled after configuration.
// - Mode chosen from three mode-select pins sampled before configuration.
// - Peripheral modes report ready when host may write next byte.
module config_port_pin_logic (
    input wire logic i_clk, // System clock, 40 MHz
    input wire logic i_rst_n, // Synchronous reset, active low
    input wire logic [2:0] i_mode_select_pins, // Mode code pins
    input wire logic i_config_clock, // External configuration clock pin
    input wire logic i_serial_din, // Serial data in, also data bit 0
    input wire logic [7:0] i_cfg_data_bus, // Byte-wide data in
    input wire logic i_select_low_n, // Active-low select
    input wire logic i_select_high_enable, // Active-high select / serial enable
    input wire logic i_write_strobe_n, // Write strobe, active low
    input wire logic i_read_strobe_n, // Read strobe, active low
    input wire logic i_init_n, // Init line level on the wire
    input wire logic i_data_error, // Frame checker saw bad data
    input wire logic i_load_done, // Frame loader has all its frames
    input wire logic i_scan_macro_used, // Loaded design holds scan macro
    output logic o_init_n_o, // Init line drive value (always 0)
    output logic o_init_n_oe, // Init line pull-low enable
    output logic o_config_active_high_flag, // High during configuration
    output logic o_config_active_low_flag, // Low during configuration
    output logic o_config_clock_o, // Master configuration clock out
    output logic o_config_clock_oe, // Configuration clock drive enable
    output logic [17:0] o_prom_addr_bus, // PROM address
    output logic o_prom_addr_oe, // PROM address drive enable
    output logic [7:0] o_cfg_data_bus_o, // Status read data
    output logic o_cfg_data_bus_oe, // Status read drive enable
    output logic o_ready_busy, // High when a byte may be written
    output logic o_serial_dout, // Serial out / downstream enable
    output logic o_cfg_bit, // Bit into the configuration path
    output logic o_cfg_bit_valid, // One-cycle strobe for o_cfg_bit
    output logic o_scan_enable, // Boundary scan functions enabled
    output logic o_user_io_active // Configuration finished
);
    typedef enum logic [2:0] {ST_CLEAR, ST_WAIT, ST_MWAIT, ST_CONFIG, ST_ERROR, ST_DONE} cfg_state_t;

    // ------------------------------------------------------------
    // Pin input synchronisers
    // ------------------------------------------------------------
    logic [2:0] config_clock_sy_ff;
    logic [2:0] init_sy_ff;
    logic [2:0] wr_sy_ff;
    logic [2:0] rd_sy_ff;
    logic [2:0] cs0_sy_ff;
    logic [2:0] cs1_sy_ff;
    logic [2:0] din_sy_ff;
    logic config_clock_q_ff;
    logic init_q_ff;
    logic wr_q_ff;
    logic rd_q_ff;
    logic cs0_q_ff;
    logic cs1_q_ff;
    logic din_q_ff;

    // Three stages; a level counts once stages two and three agree
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            config_clock_sy_ff <= 3'h0;
            init_sy_ff <= 3'h7;
            wr_sy_ff <= 3'h7;
            rd_sy_ff <= 3'h7;
            cs0_sy_ff <= 3'h7;
            cs1_sy_ff <= 3'h0;
            din_sy_ff <= 3'h0;
        end else begin
            config_clock_sy_ff <= {config_clock_sy_ff[1:0], i_config_clock};
            init_sy_ff <= {init_sy_ff[1:0], i_init_n};
            wr_sy_ff <= {wr_sy_ff[1:0], i_write_strobe_n};
            rd_sy_ff <= {rd_sy_ff[1:0], i_read_strobe_n};
            cs0_sy_ff <= {cs0_sy_ff[1:0], i_select_low_n};
            cs1_sy_ff <= {cs1_sy_ff[1:0], i_select_high_enable};
            din_sy_ff <= {din_sy_ff[1:0], i_serial_din};
        end
    end

    // Filtered levels update only when the last two stages agree
    function automatic logic filt(input logic [2:0] s, input logic q);
        filt = (s[1] == s[2]) ? s[2] : q;
    endfunction

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            config_clock_q_ff <= 1'b0;
            init_q_ff <= 1'b1;
            wr_q_ff <= 1'b1;
            rd_q_ff <= 1'b1;
            cs0_q_ff <= 1'b1;
            cs1_q_ff <= 1'b0;
            din_q_ff <= 1'b0;
        end else begin
            config_clock_q_ff <= filt(config_clock_sy_ff, config_clock_q_ff);
            init_q_ff <= filt(init_sy_ff, init_q_ff);
            wr_q_ff <= filt(wr_sy_ff, wr_q_ff);
            rd_q_ff <= filt(rd_sy_ff, rd_q_ff);
            cs0_q_ff <= filt(cs0_sy_ff, cs0_q_ff);
            cs1_q_ff <= filt(cs1_sy_ff, cs1_q_ff);
            din_q_ff <= filt(din_sy_ff, din_q_ff);
        end
    end

    // ------------------------------------------------------------
    // Mode and state
    // ------------------------------------------------------------
    cfg_state_t state_ff;
    cfg_state_t nxt_state;
    cfg_pkg::cfg_mode_t mode_ff;
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;

    wire is_master = (mode_ff == cfg_pkg::MODE_MASTER_SERIAL) || (mode_ff == cfg_pkg::MODE_MASTER_PAR_UP)
        || (mode_ff == cfg_pkg::MODE_MASTER_PAR_DOWN);
    wire is_mpar = (mode_ff == cfg_pkg::MODE_MASTER_PAR_UP) || (mode_ff == cfg_pkg::MODE_MASTER_PAR_DOWN);
    wire is_serial = (mode_ff == cfg_pkg::MODE_MASTER_SERIAL) || (mode_ff == cfg_pkg::MODE_SLAVE_SERIAL);
    wire is_express = (mode_ff == cfg_pkg::MODE_EXPRESS);
    wire is_periph = (mode_ff == cfg_pkg::MODE_PERIPH_SYNC) || (mode_ff == cfg_pkg::MODE_PERIPH_ASYNC);
    wire config_clock_internal = is_master || (mode_ff == cfg_pkg::MODE_PERIPH_ASYNC);
    wire configuring = (state_ff == ST_CONFIG) || (state_ff == ST_ERROR);
    wire done_st = (state_ff == ST_DONE);

    // Sequencing: clear, wait on init, master extra wait, configure
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            ST_CLEAR: begin
                nxt_cnt = cnt_ff + 16'h0001;
                if (cnt_ff == 16'(cfg_pkg::CLEAR_CYC - 1)) begin
                    nxt_state = ST_WAIT;
                    nxt_cnt = 16'h0000;
                end
            end
            ST_WAIT: begin
                if (init_q_ff) begin
                    nxt_state = is_master ? ST_MWAIT : ST_CONFIG;
                end
            end
            ST_MWAIT: begin
                nxt_cnt = cnt_ff + 16'h0001;
                if (!init_q_ff) begin
                    nxt_state = ST_WAIT;
                    nxt_cnt = 16'h0000;
                end else if (cnt_ff == 16'(cfg_pkg::MASTER_WAIT_CYC - 1)) begin
                    nxt_state = ST_CONFIG;
                    nxt_cnt = 16'h0000;
                end
            end
            ST_CONFIG: begin
                if (i_data_error) begin
                    nxt_state = ST_ERROR;
                end else if (i_load_done) begin
                    nxt_state = ST_DONE;
                end
            end
            ST_ERROR: nxt_state = ST_ERROR;
            ST_DONE: nxt_state = ST_DONE;
            default: nxt_state = ST_CLEAR;
        endcase
    end

    // State register; mode sampled before configuration starts
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state_ff <= ST_CLEAR;
            cnt_ff <= 16'h0000;
            mode_ff <= cfg_pkg::MODE_SLAVE_SERIAL;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            if (state_ff == ST_CLEAR || state_ff == ST_WAIT) begin
                mode_ff <= cfg_pkg::cfg_mode_t'(i_mode_select_pins);
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration clock: internal divider or external edges
    // ------------------------------------------------------------
    logic [7:0] div_ff;
    logic icclk_ff;
    logic config_clock_prev_ff;
    wire div_wrap = (div_ff == 8'(cfg_pkg::CONFIG_CLOCK_HALF_CYC - 1));
    wire int_rise = configuring && config_clock_internal && div_wrap && !icclk_ff;
    wire int_fall = configuring && config_clock_internal && div_wrap && icclk_ff;
    wire ext_rise = configuring && !config_clock_internal && config_clock_q_ff && !config_clock_prev_ff;
    wire ext_fall = configuring && !config_clock_internal && !config_clock_q_ff && config_clock_prev_ff;
    wire config_clock_rise = int_rise || ext_rise;
    wire config_clock_fall = int_fall || ext_fall;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            div_ff <= 8'h00;
            icclk_ff <= 1'b0;
            config_clock_prev_ff <= 1'b0;
        end else begin
            config_clock_prev_ff <= config_clock_q_ff;
            div_ff <= div_wrap ? 8'h00 : div_ff + 8'h01;
            if (configuring && config_clock_internal && div_wrap) begin
                icclk_ff <= !icclk_ff;
            end
        end
    end

    assign o_config_clock_o = icclk_ff;
    assign o_config_clock_oe = configuring && config_clock_internal;

    // ------------------------------------------------------------
    // Host byte capture into the buffer
    // ------------------------------------------------------------
    cfg_stream_if #(.W(8)) fill ();
    cfg_stream_if #(.W(8)) drain ();
    logic fifo_empty;
    logic wr_prev_ff;
    logic [8:0] shreg_ff;
    logic [3:0] bits_ff;
    logic busy_ff;

    wire selected = !cs0_q_ff && cs1_q_ff;
    wire wr_fall = !wr_q_ff && wr_prev_ff;
    // Serial pin is data bit zero
    wire [7:0] par_byte = {i_cfg_data_bus[7:1], i_serial_din};
    // Selected write strobe loads a byte
    wire host_wr = configuring && is_periph && selected && wr_fall;
    // Express takes a byte per rising edge while enabled
    wire exp_wr = configuring && is_express && cs1_q_ff && config_clock_rise;
    // Master parallel fetches one byte per nine rising edges
    wire mpar_wr = configuring && is_mpar && config_clock_rise && (bits_ff == 4'h0);
    // Busy until buffered bytes are serialized
    wire ready = configuring && fifo_empty && !busy_ff && !bits_ff[3] && (bits_ff == 4'h0);

    assign fill.data = par_byte;
    assign fill.valid = host_wr || exp_wr || mpar_wr;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            wr_prev_ff <= 1'b1;
            busy_ff <= 1'b0;
        end else begin
            wr_prev_ff <= wr_q_ff;
            busy_ff <= fill.valid;
        end
    end

    byte_fifo #(.WIDTH(8), .DEPTH(cfg_pkg::FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_flush(done_st),
        .wr(fill),
        .rd(drain),
        .o_empty(fifo_empty)
    );

    // ------------------------------------------------------------
    // Serializer: one bit per rising configuration clock edge
    // ------------------------------------------------------------
    assign drain.ready = configuring && !is_serial && (bits_ff == 4'h0);

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            shreg_ff <= 9'h000;
            bits_ff <= 4'h0;
        end else if (drain.valid && drain.ready) begin
            shreg_ff <= {1'b0, drain.data};
            bits_ff <= 4'h8;
        end else if (config_clock_rise && bits_ff != 4'h0) begin
            shreg_ff <= {1'b0, shreg_ff[8:1]};
            bits_ff <= bits_ff - 4'h1;
        end
    end

    // Serial modes sample input at rising edge
    assign o_cfg_bit = is_serial ? din_q_ff : shreg_ff[0];
    assign o_cfg_bit_valid = is_serial ? config_clock_rise : (config_clock_rise && bits_ff != 4'h0);

    // ------------------------------------------------------------
    // PROM address, serial out, status read
    // ------------------------------------------------------------
    logic [17:0] addr_ff;
    logic dout_ff;
    logic held_bit_ff;

    // Step PROM address per fetched byte
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            addr_ff <= cfg_pkg::ADDR_UP_START;
        end else if (!configuring) begin
            addr_ff <= (mode_ff == cfg_pkg::MODE_MASTER_PAR_DOWN) ? cfg_pkg::ADDR_DOWN_START : cfg_pkg::ADDR_UP_START;
        end else if (mpar_wr) begin
            addr_ff <= (mode_ff == cfg_pkg::MODE_MASTER_PAR_DOWN) ? addr_ff - 18'h00001 : addr_ff + 18'h00001;
        end
    end

    // Output changes on falling edge; express drives enable
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            held_bit_ff <= 1'b1;
            dout_ff <= 1'b1;
        end else begin
            if (o_cfg_bit_valid) begin
                held_bit_ff <= o_cfg_bit;
            end
            if (is_express) begin
                dout_ff <= configuring ? (i_load_done || done_st) : 1'b0;
            end else if (config_clock_fall) begin
                dout_ff <= held_bit_ff;
            end
        end
    end

    // Configuration pins released once user I/O active
    assign o_prom_addr_bus = addr_ff;
    assign o_prom_addr_oe = configuring && is_mpar;
    assign o_serial_dout = dout_ff;
    assign o_ready_busy = ready;
    assign o_cfg_data_bus_oe = configuring && (mode_ff == cfg_pkg::MODE_PERIPH_ASYNC) && selected
        && !rd_q_ff && wr_q_ff;
    assign o_cfg_data_bus_o = {ready, 7'h7F};

    // ------------------------------------------------------------
    // Flags and init line
    // ------------------------------------------------------------
    // Flags until user I/O active
    assign o_config_active_high_flag = !done_st;
    assign o_config_active_low_flag = done_st;
    assign o_user_io_active = done_st;
    // Pull init low while clearing or on error
    assign o_init_n_o = 1'b0;
    assign o_init_n_oe = (state_ff == ST_CLEAR) || (state_ff == ST_ERROR);
    // Scan disabled after configuration unless macro used
    assign o_scan_enable = !done_st || i_scan_macro_used;
endmodule

//--- tb/cfg_serial_src.sv
`timescale 1ns/100ps
// Serial configuration source on the far side of the data pins
module cfg_serial_src (
    output logic o_config_clock, // Link clock, still between frames
    output logic o_din // Serial data
);
    initial begin
        o_config_clock = 1'b0;
        o_din = 1'b0;
    end
    // One byte, LSB first, 200 ns per bit
    task automatic send(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            // Bit set up half a period before rise
            o_din = b[i];
            #100 o_config_clock = 1'b1;
            #100 o_config_clock = 1'b0;
        end
        o_din = ~b[7]; // Released line: stale value must not be trusted
    endtask
endmodule

//--- tb/config_port_pin_logic_assertions.sv
`timescale 1ns/100ps
module config_port_pin_logic_assertions (
    input wire logic i_clk, // System clock
    input wire logic i_rst_n, // Reset, active low
    input wire logic [2:0] i_mode_select_pins, // Mode code
    input wire logic i_init_n, // Init wire level
    input wire logic i_write_strobe_n, // Write strobe
    input wire logic i_read_strobe_n, // Read strobe
    input wire logic o_init_n_oe, // Init pull-low
    input wire logic o_config_active_high_flag, // High flag
    input wire logic o_config_active_low_flag, // Low flag
    input wire logic o_config_clock_o, // Internal clock
    input wire logic o_config_clock_oe, // Clock enable
    input wire logic [17:0] o_prom_addr_bus, // PROM address
    input wire logic o_prom_addr_oe, // Address enable
    input wire logic [7:0] o_cfg_data_bus_o, // Status byte
    input wire logic o_cfg_data_bus_oe, // Status enable
    input wire logic o_ready_busy, // Ready
    input wire logic o_serial_dout, // Serial out
    input wire logic o_cfg_bit_valid, // Bit strobe
    input wire logic o_user_io_active // Done
);
    localparam int WAIT_LO = 2000;
    localparam int WAIT_HI = 10000;
    int high_cnt_ff;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // Cycles the init line has stood high
    always_ff @(posedge i_clk) begin
        high_cnt_ff <= (i_rst_n && i_init_n) ? high_cnt_ff + 1 : 0;
    end
    a_init_clear: assert property (
        $rose(i_rst_n) |-> o_init_n_oe [*8]) else $error("init not pulled low in clear");
    a_flag_pair: assert property (
        o_config_active_high_flag == !o_config_active_low_flag && o_config_active_high_flag == !o_user_io_active)
        else $error("configuration flags disagree");
    a_start_hold: assert property (
        $rose(o_config_clock_oe) |-> high_cnt_ff >= 3) else $error("started while init low");
    a_master_wait: assert property (
        $rose(o_config_clock_oe) && i_mode_select_pins inside {3'h0, 3'h4, 3'h6}
        |-> high_cnt_ff >= WAIT_LO && high_cnt_ff <= WAIT_HI) else $error("master wait out of range");
    a_write_wins: assert property (
        (!i_write_strobe_n && !i_read_strobe_n) [*4] |-> !o_cfg_data_bus_oe) else $error("read served in write");
    a_read_status: assert property (
        o_cfg_data_bus_oe |-> o_cfg_data_bus_o == {o_ready_busy, 7'h7F}) else $error("bad status byte");
    a_dout_fall: assert property (
        o_config_clock_oe && !o_user_io_active && $changed(o_serial_dout) |-> !o_config_clock_o)
        else $error("serial out moved outside clock low");
    a_bit_pulse: assert property (
        o_cfg_bit_valid |=> !o_cfg_bit_valid) else $error("bit strobe longer than one cycle");
    a_addr_start: assert property (
        $rose(o_prom_addr_oe) |-> o_prom_addr_bus == (i_mode_select_pins == 3'h6 ? 18'h3FFFF : 18'h00000))
        else $error("bad first PROM address");
    a_done_pins: assert property (
        o_user_io_active |-> !o_init_n_oe && !o_config_clock_oe && !o_prom_addr_oe && !o_cfg_data_bus_oe)
        else $error("configuration pin active after done");
endmodule
bind config_port_pin_logic config_port_pin_logic_assertions u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_mode_select_pins(i_mode_select_pins), .i_init_n(i_init_n), .i_write_strobe_n(i_write_strobe_n),
    .i_read_strobe_n(i_read_strobe_n), .o_init_n_oe(o_init_n_oe), .o_config_active_high_flag(o_config_active_high_flag),
    .o_config_active_low_flag(o_config_active_low_flag), .o_config_clock_o(o_config_clock_o),
    .o_config_clock_oe(o_config_clock_oe), .o_prom_addr_bus(o_prom_addr_bus), .o_prom_addr_oe(o_prom_addr_oe),
    .o_cfg_data_bus_o(o_cfg_data_bus_o), .o_cfg_data_bus_oe(o_cfg_data_bus_oe), .o_ready_busy(o_ready_busy),
    .o_serial_dout(o_serial_dout), .o_cfg_bit_valid(o_cfg_bit_valid), .o_user_io_active(o_user_io_active));

//--- tb/tb_config_port_pin_logic.sv
`timescale 1ns/100ps
module tb_config_port_pin_logic;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [2:0] mode = 3'h7;
    logic [7:0] bus = 8'h00;
    logic d0 = 1'b0, use_src = 1'b1, hold_init = 1'b0, err = 1'b0, done = 1'b0, macro = 1'b0;
    logic sel_n = 1'b1, sel = 1'b0, wr_n = 1'b1, rd_n = 1'b1;
    wire logic init_oe, hi_flag, lo_flag, clk_oe, addr_oe, dbus_oe, rdy, dout, bit_v, bit_d, scan_en, io_act;
    wire logic src_clk, src_din;
    wire logic [7:0] dbus_o;
    wire logic [17:0] addr;
    logic exp_q[$];
    int err_count = 0;
    int tests_run = 0;
    // Clock and far side
    always #12.5 i_clk = ~i_clk;
    cfg_serial_src src (.o_config_clock(src_clk), .o_din(src_din));
    config_port_pin_logic dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_mode_select_pins(mode),
        .i_config_clock(src_clk), .i_serial_din(use_src ? src_din : d0), .i_cfg_data_bus(bus),
        .i_select_low_n(sel_n), .i_select_high_enable(sel), .i_write_strobe_n(wr_n), .i_read_strobe_n(rd_n),
        .i_init_n(!(init_oe || hold_init)), .i_data_error(err), .i_load_done(done), .i_scan_macro_used(macro),
        .o_init_n_o(), .o_init_n_oe(init_oe), .o_config_active_high_flag(hi_flag), .o_config_active_low_flag(lo_flag),
        .o_config_clock_o(), .o_config_clock_oe(clk_oe), .o_prom_addr_bus(addr), .o_prom_addr_oe(addr_oe),
        .o_cfg_data_bus_o(dbus_o), .o_cfg_data_bus_oe(dbus_oe), .o_ready_busy(rdy), .o_serial_dout(dout),
        .o_cfg_bit(bit_d), .o_cfg_bit_valid(bit_v), .o_scan_enable(scan_en), .o_user_io_active(io_act));
    // Compare tasks and verdict
    task automatic chk_pin(input logic [7:0] got, input logic [7:0] e);
        tests_run++;
        if (got !== e) begin
            err_count++;
            $display("BAD %0t pin %h exp %h", $time, got, e);
        end
    endtask
    task automatic chk_bit(input logic got);
        logic e;
        tests_run++;
        e = exp_q.size() > 0 ? exp_q.pop_front() : 1'bx;
        if (got !== e) begin
            err_count++;
            $display("BAD %0t bit %b exp %b", $time, got, e);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Stimulus helpers
    task automatic do_reset(input logic [2:0] m);
        @(negedge i_clk);
        i_rst_n = 1'b0;
        mode = m;
        err = 1'b0;
        done = 1'b0;
        repeat (20) @(negedge i_clk);
        i_rst_n = 1'b1;
    endtask
    task automatic host_wr(input logic [7:0] b, input logic both, input logic take);
        for (int n = 0; n < 3000 && rdy !== 1'b1; n++) @(negedge i_clk);
        bus = b ^ 8'h01;
        d0 = b[0];
        wr_n = 1'b0;
        rd_n = !both;
        for (int i = 0; i < 8 && take; i++) exp_q.push_back(b[i]);
        repeat (6) @(negedge i_clk);
        wr_n = 1'b1;
        rd_n = 1'b1;
        repeat (2) @(negedge i_clk);
    endtask
    task automatic rd_stat(input logic [7:0] e);
        rd_n = 1'b0;
        repeat (6) @(negedge i_clk);
        chk_pin(dbus_o, e);
        chk_pin(8'(dbus_oe), 8'h01);
        rd_n = 1'b1;
        repeat (6) @(negedge i_clk);
    endtask
    // Bit stream monitor against the queue model
    always @(negedge i_clk) if (i_rst_n === 1'b1 && bit_v === 1'b1) chk_bit(bit_d);
    // Watchdog: about 19000 cycles are expected, allow 60000
    initial begin
        #1500000;
        err_count++;
        $display("BAD %0t timeout", $time);
        stop_test;
    end
    // Main sequence
    initial begin
        int n;
        logic [7:0] b;
        b = 8'($urandom(76));
        for (int m = 0; m < 8; m++) begin
            do_reset(3'(m));
            for (n = 0; n < 2600 && clk_oe !== 1'b1; n++) @(negedge i_clk);
            chk_pin(8'({clk_oe, addr_oe, hi_flag, lo_flag, n >= 2064}),
                8'({m inside {0, 4, 5, 6}, m inside {4, 6}, 2'b10, m != 5}));
            if (m == 2) chk_pin(8'(dout), 8'h00);
            chk_pin(addr[7:0], m == 6 ? 8'hFF : 8'h00);
        end
        $display("test modes done");
        hold_init = 1'b1;
        do_reset(3'h7);
        repeat (200) @(negedge i_clk);
        src.send(8'($urandom));
        hold_init = 1'b0;
        repeat (20) @(negedge i_clk);
        b = 8'($urandom);
        for (int i = 0; i < 8; i++) exp_q.push_back(b[i]);
        src.send(b);
        repeat (10) @(negedge i_clk);
        chk_pin(8'(exp_q.size()), 8'h00);
        err = 1'b1;
        repeat (10) @(negedge i_clk);
        err = 1'b0;
        repeat (10) @(negedge i_clk);
        chk_pin(8'({init_oe, hi_flag}), 8'h03);
        $display("test serial done");
        do_reset(3'h2);
        use_src = 1'b0;
        sel_n = 1'b0;
        sel = 1'b1;
        b = 8'($urandom);
        bus = b;
        d0 = b[0];
        repeat (100) @(negedge i_clk);
        for (int i = 0; i < 7; i++) exp_q.push_back(b[i]);
        src.send(8'h00);
        repeat (10) @(negedge i_clk);
        chk_pin(8'(exp_q.size()), 8'h00);
        do_reset(3'h5);
        host_wr(8'($urandom), 1'b0, 1'b1);
        rd_stat(8'h7F);
        host_wr(8'($urandom), 1'b1, 1'b1);
        host_wr(8'($urandom), 1'b0, 1'b1);
        repeat (400) @(negedge i_clk);
        rd_stat(8'hFF);
        sel = 1'b0;
        host_wr(8'($urandom), 1'b1, 1'b0);
        repeat (400) @(negedge i_clk);
        chk_pin(8'({exp_q.size() == 0, dbus_oe}), 8'h02);
        $display("test peripheral done");
        do_reset(3'h7);
        use_src = 1'b1;
        repeat (100) @(negedge i_clk);
        macro = 1'($urandom);
        done = 1'b1;
        repeat (10) @(negedge i_clk);
        chk_pin(8'({hi_flag, lo_flag, io_act, scan_en, init_oe}), 8'({3'b011, macro, 1'b0}));
        $display("test done state done");
        stop_test;
    end
endmodule
